// >>> common/bos_pkg.sv
// Constants and types shared by the bit-operation and skip execution block
// Functional notes
// - Clearing an I/O port bit drives it to 0; arithmetic flags stay unchanged.
// - Forcing an I/O port bit drives it to 1; arithmetic flags stay unchanged.
// - Bit-carry exchange swaps an I/O bit with carry; only carry may change.
// - For an output port bit, the exchange copies the old carry onto that bit.
// - For an input port bit, the exchange loads the sampled pin level into carry.
// - Direction bit 1 makes the pin an output, 0 makes it an input.
// - Clearing a memory bit writes 0 there; other bits and flags unchanged.
// - Forcing a memory bit writes 1 there; other bits and flags unchanged.
// - Equal-skip compares work register with immediate or memory, skips when equal.
// - Unequal-skip compares work register with immediate or memory, skips when different.
// - Both compare-skips set all four flags as for work register minus operand.
// - Low-bit skip on I/O skips when the port bit reads 0; no flag change.
// - High-bit skip on I/O skips when the port bit reads 1; no flag change.
// - Low-bit skip on memory skips when the bit is 0; no flag change.
// - High-bit skip on memory skips when the bit is 1; no flag change.
// - Increment-zero-skip adds one, stores, sets four flags, skips on zero result.
package bos_pkg;

  typedef enum logic [3:0] {
    BOS_OP_NONE,
    BOS_OP_CLR_IO,
    BOS_OP_SET_IO,
    BOS_OP_SWAPC_IO,
    BOS_OP_CLR_MEM,
    BOS_OP_SET_MEM,
    BOS_OP_CEQ_IMM,
    BOS_OP_CEQ_MEM,
    BOS_OP_CNE_IMM,
    BOS_OP_CNE_MEM,
    BOS_OP_T0_IO,
    BOS_OP_T1_IO,
    BOS_OP_T0_MEM,
    BOS_OP_T1_MEM,
    BOS_OP_INCZ_ACC
  } bos_op_t;

  // I/O register addresses, also the register port addresses
  localparam logic [7:0] IO_FLAGS = 8'h00;
  localparam logic [7:0] IO_PORT1_DATA = 8'h10;
  localparam logic [7:0] IO_PORT1_DIR = 8'h11;
  localparam logic [7:0] IO_PORT2_DATA = 8'h14;
  localparam logic [7:0] IO_PORT2_DIR = 8'h15;
  localparam logic [7:0] REG_WORK = 8'h20;
  localparam logic [7:0] REG_MEM_BASE = 8'h40;
  localparam logic [7:0] REG_MEM_MASK = 8'hC0;

  // Flag positions inside the flags register
  localparam int FLAG_Z = 0;
  localparam int FLAG_C = 1;
  localparam int FLAG_AC = 2;
  localparam int FLAG_OV = 3;

  // Values after reset
  localparam logic [7:0] RST_WORK = 8'h00;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic [7:0] RST_PORT_DATA = 8'h00;
  localparam logic [7:0] RST_PORT_DIR = 8'h00;
  localparam logic [7:0] RST_MEM = 8'h00;

endpackage

// >>> sim/bos_exec_properties.sv
// Concurrent checks on the ports of the bit-operation and skip execution block
`timescale 1ns/1ps
module bos_exec_chk (
  input wire logic MCLK, // Clock
  input wire logic RSTN, // Reset, low
  input wire logic OP_VALID, // Valid
  input wire bos_pkg::bos_op_t OP_CODE, // Operation
  input wire logic [2:0] OP_BIT, // Bit number
  input wire logic [7:0] OP_ADDR, // Address
  input wire logic [7:0] OP_IMM, // Immediate
  input wire logic OP_SKIPPED, // Skip pulse
  input wire logic SKIP_PENDING, // Skip level
  input wire logic [7:0] WORK_REG, // Work register
  input wire logic [3:0] FLAGS, // Flags
  input wire logic [7:0] BUS_ADDR, // Bus address
  input wire logic [7:0] BUS_WDATA, // Bus data
  input wire logic BUS_WR, // Bus write
  input wire logic [7:0] PORT1_OUT, // Port one latch
  input wire logic [7:0] PORT1_OE_N, // Port one enable
  input wire logic [7:0] PORT2_OUT // Port two latch
);
  logic go;
  logic sel1;
  logic cy;
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!RSTN);
  // Instruction really executed, no competing bus write
  assign go = OP_VALID && !SKIP_PENDING && !BUS_WR;
  assign sel1 = PORT1_OUT[OP_BIT];
  assign cy = FLAGS[1];
  clr_io_a: assert property (go && OP_CODE == bos_pkg::BOS_OP_CLR_IO && OP_ADDR == bos_pkg::IO_PORT1_DATA
    |=> !PORT1_OUT[$past(OP_BIT)] && $stable(FLAGS)) else $error("port bit not cleared");
  set_io_a: assert property (go && OP_CODE == bos_pkg::BOS_OP_SET_IO && OP_ADDR == bos_pkg::IO_PORT2_DATA
    |=> PORT2_OUT[$past(OP_BIT)] && $stable(FLAGS)) else $error("port bit not forced");
  swap_out_a: assert property (go && OP_CODE == bos_pkg::BOS_OP_SWAPC_IO && !PORT1_OE_N[OP_BIT]
    && OP_ADDR == bos_pkg::IO_PORT1_DATA |=> PORT1_OUT[$past(OP_BIT)] == $past(cy) && cy == $past(sel1)
    && (FLAGS & 4'hD) == ($past(FLAGS) & 4'hD)) else $error("carry exchange wrong");
  dir_set_a: assert property (BUS_WR && !OP_VALID && BUS_ADDR == bos_pkg::IO_PORT1_DIR
    |=> PORT1_OE_N == ~$past(BUS_WDATA)) else $error("direction not applied");
  ceq_skip_a: assert property (go && OP_CODE == bos_pkg::BOS_OP_CEQ_IMM
    |=> SKIP_PENDING == ($past(WORK_REG) == $past(OP_IMM)) && $stable(WORK_REG)) else $error("equal skip wrong");
  cne_skip_a: assert property (go && OP_CODE == bos_pkg::BOS_OP_CNE_IMM
    |=> SKIP_PENDING == ($past(WORK_REG) != $past(OP_IMM)) && cy == ($past(WORK_REG) < $past(OP_IMM)))
    else $error("unequal skip wrong");
  bit_skip_a: assert property (go && OP_CODE == bos_pkg::BOS_OP_T1_IO && !PORT1_OE_N[OP_BIT]
    && OP_ADDR == bos_pkg::IO_PORT1_DATA |=> SKIP_PENDING == $past(sel1) && $stable(FLAGS))
    else $error("bit skip wrong");
  incz_skip_a: assert property (go && OP_CODE == bos_pkg::BOS_OP_INCZ_ACC
    |=> WORK_REG == $past(WORK_REG) + 8'h01 && SKIP_PENDING == (WORK_REG == 8'h00)
    && FLAGS[0] == (WORK_REG == 8'h00)) else $error("increment skip wrong");
  skip_eat_a: assert property (OP_VALID && SKIP_PENDING && !BUS_WR |=> OP_SKIPPED && !SKIP_PENDING
    && $stable(WORK_REG) && $stable(FLAGS) && $stable(PORT1_OUT)) else $error("skipped instruction had effect");
  cover property (go && OP_CODE == bos_pkg::BOS_OP_CEQ_IMM ##1 SKIP_PENDING);
  cover property (go && OP_CODE == bos_pkg::BOS_OP_INCZ_ACC ##1 SKIP_PENDING);
  cover property (OP_SKIPPED);
endmodule // bos_exec_chk

bind bos_exec bos_exec_chk i_chk (.MCLK(MCLK), .RSTN(RSTN), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
  .OP_BIT(OP_BIT), .OP_ADDR(OP_ADDR), .OP_IMM(OP_IMM), .OP_SKIPPED(OP_SKIPPED), .SKIP_PENDING(SKIP_PENDING),
  .WORK_REG(WORK_REG), .FLAGS(FLAGS), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_WR(BUS_WR),
  .PORT1_OUT(PORT1_OUT), .PORT1_OE_N(PORT1_OE_N), .PORT2_OUT(PORT2_OUT));

// >>> sim/tb_top.sv
// Self-checking bench for the bit-operation and skip execution block
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    num_checks++; \
    if ((a) !== (b)) begin \
      error_cnt++; \
      $display("ERROR %0t %0h %0h", $time, (a), (b)); \
    end \
  end
module tb_top;
  logic MCLK = 1'b0;
  logic RSTN = 1'b0;
  logic OP_VALID = 1'b0;
  bos_pkg::bos_op_t OP_CODE = bos_pkg::BOS_OP_NONE;
  logic [2:0] OP_BIT = 3'h0;
  logic [7:0] OP_ADDR = 8'h00, OP_IMM = 8'h00, BUS_ADDR = 8'h00, BUS_WDATA = 8'h00;
  logic BUS_WR = 1'b0, BUS_RD = 1'b0;
  logic [7:0] PORT1_IN = 8'h01, PORT2_IN = 8'h5A;
  logic OP_SKIPPED, SKIP_PENDING;
  logic [7:0] WORK_REG, BUS_RDATA, PORT1_OUT, PORT1_OE_N, PORT2_OUT, PORT2_OE_N, d;
  logic [3:0] FLAGS;
  int error_cnt = 0;
  int num_checks = 0;
  always #20 MCLK = ~MCLK;
  bos_exec #(.MEM_DEPTH(16), .MEM_AW(4)) i_dut (.MCLK(MCLK), .RSTN(RSTN), .OP_VALID(OP_VALID),
    .OP_CODE(OP_CODE), .OP_BIT(OP_BIT), .OP_ADDR(OP_ADDR), .OP_IMM(OP_IMM), .OP_SKIPPED(OP_SKIPPED),
    .SKIP_PENDING(SKIP_PENDING), .WORK_REG(WORK_REG), .FLAGS(FLAGS), .BUS_ADDR(BUS_ADDR),
    .BUS_WDATA(BUS_WDATA), .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_RDATA(BUS_RDATA), .PORT1_IN(PORT1_IN),
    .PORT1_OUT(PORT1_OUT), .PORT1_OE_N(PORT1_OE_N), .PORT2_IN(PORT2_IN), .PORT2_OUT(PORT2_OUT),
    .PORT2_OE_N(PORT2_OE_N));
  task automatic finish_test;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Ends a transfer at the edge that takes it, then lets outputs settle
  task automatic fin;
    @(posedge MCLK);
    OP_VALID <= 1'b0;
    BUS_WR <= 1'b0;
    BUS_RD <= 1'b0;
    #1;
  endtask
  task automatic op(bos_pkg::bos_op_t c, logic [2:0] b, logic [7:0] a, logic [7:0] i);
    @(posedge MCLK);
    OP_VALID <= 1'b1;
    OP_CODE <= c;
    OP_BIT <= b;
    OP_ADDR <= a;
    OP_IMM <= i;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge MCLK);
    BUS_WR <= 1'b1;
    BUS_ADDR <= a;
    BUS_WDATA <= v;
    fin();
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge MCLK);
    BUS_RD <= 1'b1;
    BUS_ADDR <= a;
    fin();
    d = BUS_RDATA;
  endtask
  task automatic t_io;
    wr(bos_pkg::IO_PORT1_DIR, 8'hF0);
    `CHK({PORT1_OE_N, PORT2_OE_N}, {8'h0F, 8'hFF})
    wr(bos_pkg::IO_FLAGS, 8'h0F);
    op(bos_pkg::BOS_OP_SET_IO, 3'h6, bos_pkg::IO_PORT1_DATA, 8'h00);
    op(bos_pkg::BOS_OP_CLR_IO, 3'h6, bos_pkg::IO_PORT1_DATA, 8'h00);
    op(bos_pkg::BOS_OP_SET_IO, 3'h3, bos_pkg::IO_PORT2_DATA, 8'h00);
    fin();
    `CHK({PORT1_OUT, PORT2_OUT, FLAGS}, {8'h00, 8'h08, 4'hF})
    op(bos_pkg::BOS_OP_SWAPC_IO, 3'h4, bos_pkg::IO_PORT1_DATA, 8'h00);
    fin();
    `CHK({PORT1_OUT[4], FLAGS}, {1'b1, 4'hD})
    op(bos_pkg::BOS_OP_SWAPC_IO, 3'h0, bos_pkg::IO_PORT1_DATA, 8'h00);
    fin();
    `CHK(FLAGS, 4'hF)
    op(bos_pkg::BOS_OP_SWAPC_IO, 3'h1, bos_pkg::IO_PORT1_DATA, 8'h00);
    fin();
    `CHK(FLAGS, 4'hD)
  endtask
  task automatic t_mem;
    wr(8'h43, 8'hA5);
    op(bos_pkg::BOS_OP_CLR_MEM, 3'h0, 8'h03, 8'h00);
    op(bos_pkg::BOS_OP_SET_MEM, 3'h1, 8'h03, 8'h00);
    fin();
    rd(8'h43);
    `CHK({d, FLAGS}, {8'hA6, 4'hD})
    rd(8'h30);
    `CHK(d, 8'h00)
    wr(8'h45, 8'h42);
    wr(8'h46, 8'h01);
  endtask
  // One skip-type instruction, then an increment that is eaten when a skip is due
  task automatic sk(bos_pkg::bos_op_t c, logic [2:0] b, logic [7:0] a, logic [7:0] i, logic [7:0] w,
      logic [7:0] we, logic s, logic [3:0] f);
    wr(bos_pkg::REG_WORK, w);
    wr(bos_pkg::IO_FLAGS, 8'h0A);
    op(c, b, a, i);
    fin();
    `CHK({SKIP_PENDING, FLAGS, WORK_REG}, {s, f, we})
    op(bos_pkg::BOS_OP_INCZ_ACC, 3'h0, 8'h00, 8'h00);
    fin();
    `CHK({OP_SKIPPED, SKIP_PENDING, WORK_REG}, {s, 1'b0, s ? we : we + 8'h01})
  endtask
  task automatic t_skip;
    sk(bos_pkg::BOS_OP_CEQ_IMM, 3'h0, 8'h00, 8'h38, 8'h38, 8'h38, 1'b1, 4'h1);
    sk(bos_pkg::BOS_OP_CNE_IMM, 3'h0, 8'h00, 8'h42, 8'h38, 8'h38, 1'b1, 4'h2);
    sk(bos_pkg::BOS_OP_CNE_IMM, 3'h0, 8'h00, 8'h55, 8'h55, 8'h55, 1'b0, 4'h1);
    sk(bos_pkg::BOS_OP_CEQ_MEM, 3'h0, 8'h05, 8'h00, 8'h38, 8'h38, 1'b0, 4'h2);
    sk(bos_pkg::BOS_OP_CNE_MEM, 3'h0, 8'h06, 8'h00, 8'h80, 8'h80, 1'b1, 4'hC);
    sk(bos_pkg::BOS_OP_T1_IO, 3'h4, bos_pkg::IO_PORT1_DATA, 8'h00, 8'h33, 8'h33, 1'b1, 4'hA);
    sk(bos_pkg::BOS_OP_T1_IO, 3'h2, bos_pkg::IO_PORT2_DATA, 8'h00, 8'h33, 8'h33, 1'b0, 4'hA);
    sk(bos_pkg::BOS_OP_T0_IO, 3'h1, bos_pkg::IO_PORT2_DATA, 8'h00, 8'h33, 8'h33, 1'b0, 4'hA);
    sk(bos_pkg::BOS_OP_T0_IO, 3'h2, bos_pkg::IO_PORT2_DATA, 8'h00, 8'h33, 8'h33, 1'b1, 4'hA);
    sk(bos_pkg::BOS_OP_T0_MEM, 3'h0, 8'h03, 8'h00, 8'h33, 8'h33, 1'b1, 4'hA);
    sk(bos_pkg::BOS_OP_T1_MEM, 3'h7, 8'h03, 8'h00, 8'h33, 8'h33, 1'b1, 4'hA);
    sk(bos_pkg::BOS_OP_T1_MEM, 3'h0, 8'h03, 8'h00, 8'h33, 8'h33, 1'b0, 4'hA);
    sk(bos_pkg::BOS_OP_INCZ_ACC, 3'h0, 8'h00, 8'h00, 8'hFF, 8'h00, 1'b1, 4'h7);
    sk(bos_pkg::BOS_OP_INCZ_ACC, 3'h0, 8'h00, 8'h00, 8'h7F, 8'h80, 1'b0, 4'hC);
  endtask
  initial begin
    repeat (2) @(posedge MCLK);
    RSTN <= 1'b1;
    repeat (4) @(posedge MCLK);
    t_io();
    t_mem();
    t_skip();
    finish_test();
  end
  initial begin
    #40000;
    error_cnt++;
    finish_test();
  end
endmodule // tb_top

// >>> src/bos_exec.sv
// Execution unit for bit operations and conditional skips
`timescale 1ns/1ps
module bos_exec #(
  parameter int MEM_DEPTH = 16,
  parameter int MEM_AW = 4
) (
  input wire logic MCLK, // Core clock, 25 MHz
  input wire logic RSTN, // Asynchronous reset, active low
  input wire logic OP_VALID, // Instruction present this cycle
  input wire bos_pkg::bos_op_t OP_CODE, // Decoded operation
  input wire logic [2:0] OP_BIT, // Selected bit number
  input wire logic [7:0] OP_ADDR, // I/O address or memory address
  input wire logic [7:0] OP_IMM, // Immediate operand
  output logic OP_SKIPPED, // Pulse: previous instruction was consumed as skipped
  output logic SKIP_PENDING, // Next instruction will be suppressed
  output logic [7:0] WORK_REG, // Work register
  output logic [3:0] FLAGS, // Z, C, AC, OV
  input wire logic [7:0] BUS_ADDR, // Register port address
  input wire logic [7:0] BUS_WDATA, // Register port write data
  input wire logic BUS_WR, // Register write strobe
  input wire logic BUS_RD, // Register read strobe
  output logic [7:0] BUS_RDATA, // Read data, cycle after strobe
  input wire logic [7:0] PORT1_IN, // Port one pin levels
  output logic [7:0] PORT1_OUT, // Port one output levels
  output logic [7:0] PORT1_OE_N, // Port one drive enable, low drives
  input wire logic [7:0] PORT2_IN, // Port two pin levels
  output logic [7:0] PORT2_OUT, // Port two output levels
  output logic [7:0] PORT2_OE_N // Port two drive enable, low drives
);

  logic [7:0] work_register_reg, work_register_next;
  logic [3:0] flags_reg, flags_next;
  logic [7:0] port_one_data_reg, port_one_data_next;
  logic [7:0] port_one_dir_reg, port_one_dir_next;
  logic [7:0] port_two_data_reg, port_two_data_next;
  logic [7:0] port_two_dir_reg, port_two_dir_next;
  logic [7:0] mem_reg [MEM_DEPTH];
  logic [7:0] mem_next [MEM_DEPTH];
  logic skip_reg, skip_next;
  logic skipped_reg, skipped_next;
  logic [7:0] rdata_reg, rdata_next;

  logic [7:0] port_one_pin;
  logic [7:0] port_two_pin;
  logic [7:0] port_one_view;
  logic [7:0] port_two_view;
  logic [7:0] io_latch;
  logic [7:0] io_view;
  logic [MEM_AW-1:0] mem_idx;
  logic [7:0] mem_byte;
  logic [7:0] cmp_operand;
  logic alu_inc;
  logic [7:0] alu_result;
  logic [3:0] alu_flags;
  logic execute;
  logic io_bit;
  logic mem_bit;
  logic io_wen;
  logic [7:0] io_wval;
  logic mem_wen;
  logic [7:0] mem_wval;

  bos_pin_sync #(
    .WIDTH(8)
  ) u_sync_one (
    .clk(MCLK),
    .rst_n(RSTN),
    .pin_in(PORT1_IN),
    .level_out(port_one_pin)
  );

  bos_pin_sync #(
    .WIDTH(8)
  ) u_sync_two (
    .clk(MCLK),
    .rst_n(RSTN),
    .pin_in(PORT2_IN),
    .level_out(port_two_pin)
  );

  // Output bits read back the latch, input bits read the filtered pin
  assign port_one_view = (port_one_dir_reg & port_one_data_reg) | (~port_one_dir_reg & port_one_pin);
  assign port_two_view = (port_two_dir_reg & port_two_data_reg) | (~port_two_dir_reg & port_two_pin);

  // Stored latch and read view of the I/O register under the instruction
  always_comb begin
    io_latch = 8'h00;
    io_view = 8'h00;
    case (OP_ADDR)
      bos_pkg::IO_FLAGS: begin
        io_latch = {4'h0, flags_reg};
        io_view = {4'h0, flags_reg};
      end
      bos_pkg::IO_PORT1_DATA: begin
        io_latch = port_one_data_reg;
        io_view = port_one_view;
      end
      bos_pkg::IO_PORT1_DIR: begin
        io_latch = port_one_dir_reg;
        io_view = port_one_dir_reg;
      end
      bos_pkg::IO_PORT2_DATA: begin
        io_latch = port_two_data_reg;
        io_view = port_two_view;
      end
      bos_pkg::IO_PORT2_DIR: begin
        io_latch = port_two_dir_reg;
        io_view = port_two_dir_reg;
      end
      default: begin
        io_latch = 8'h00;
        io_view = 8'h00;
      end
    endcase
  end

  assign mem_idx = OP_ADDR[MEM_AW-1:0];
  assign mem_byte = mem_reg[mem_idx];
  assign io_bit = io_view[OP_BIT];
  assign mem_bit = mem_byte[OP_BIT];
  assign cmp_operand = (OP_CODE == bos_pkg::BOS_OP_CEQ_IMM || OP_CODE == bos_pkg::BOS_OP_CNE_IMM) ? OP_IMM : mem_byte;
  assign alu_inc = (OP_CODE == bos_pkg::BOS_OP_INCZ_ACC);
  assign execute = OP_VALID && !skip_reg;

  // One shared subtractor; the increment reuses it
  bos_flag_alu u_alu (
    .a(work_register_reg),
    .b(cmp_operand),
    .inc(alu_inc),
    .result(alu_result),
    .flags(alu_flags)
  );

  always_comb begin
    work_register_next = work_register_reg;
    flags_next = flags_reg;
    port_one_data_next = port_one_data_reg;
    port_one_dir_next = port_one_dir_reg;
    port_two_data_next = port_two_data_reg;
    port_two_dir_next = port_two_dir_reg;
    mem_next = mem_reg;
    skip_next = skip_reg;
    skipped_next = 1'b0;
    io_wen = 1'b0;
    io_wval = io_latch;
    mem_wen = 1'b0;
    mem_wval = mem_byte;

    // Register port write is applied first; an instruction in the same cycle overrides it
    if (BUS_WR) begin
      case (BUS_ADDR)
        bos_pkg::IO_FLAGS: flags_next = BUS_WDATA[3:0];
        bos_pkg::IO_PORT1_DATA: port_one_data_next = BUS_WDATA;
        bos_pkg::IO_PORT1_DIR: port_one_dir_next = BUS_WDATA;
        bos_pkg::IO_PORT2_DATA: port_two_data_next = BUS_WDATA;
        bos_pkg::IO_PORT2_DIR: port_two_dir_next = BUS_WDATA;
        bos_pkg::REG_WORK: work_register_next = BUS_WDATA;
        default: begin
          if ((BUS_ADDR & bos_pkg::REG_MEM_MASK) == bos_pkg::REG_MEM_BASE && BUS_ADDR[5:0] < MEM_DEPTH) begin
            mem_next[BUS_ADDR[MEM_AW-1:0]] = BUS_WDATA;
          end
        end
      endcase
    end

    // A suppressed instruction only clears the pending skip and raises the skipped pulse
    if (OP_VALID && skip_reg) begin
      skip_next = 1'b0;
      skipped_next = 1'b1;
    end

    if (execute) begin
      skip_next = 1'b0;
      case (OP_CODE)
        bos_pkg::BOS_OP_CLR_IO: begin
          io_wen = 1'b1;
          io_wval[OP_BIT] = 1'b0;
        end
        bos_pkg::BOS_OP_SET_IO: begin
          io_wen = 1'b1;
          io_wval[OP_BIT] = 1'b1;
        end
        bos_pkg::BOS_OP_SWAPC_IO: begin
          io_wen = 1'b1;
          io_wval[OP_BIT] = flags_reg[bos_pkg::FLAG_C];
          flags_next[bos_pkg::FLAG_C] = io_bit;
        end
        bos_pkg::BOS_OP_CLR_MEM: begin
          mem_wen = 1'b1;
          mem_wval[OP_BIT] = 1'b0;
        end
        bos_pkg::BOS_OP_SET_MEM: begin
          mem_wen = 1'b1;
          mem_wval[OP_BIT] = 1'b1;
        end
        bos_pkg::BOS_OP_CEQ_IMM, bos_pkg::BOS_OP_CEQ_MEM: begin
          flags_next = alu_flags;
          skip_next = (work_register_reg == cmp_operand);
        end
        bos_pkg::BOS_OP_CNE_IMM, bos_pkg::BOS_OP_CNE_MEM: begin
          flags_next = alu_flags;
          skip_next = (work_register_reg != cmp_operand);
        end
        bos_pkg::BOS_OP_T0_IO: skip_next = !io_bit;
        bos_pkg::BOS_OP_T1_IO: skip_next = io_bit;
        bos_pkg::BOS_OP_T0_MEM: skip_next = !mem_bit;
        bos_pkg::BOS_OP_T1_MEM: skip_next = mem_bit;
        bos_pkg::BOS_OP_INCZ_ACC: begin
          work_register_next = alu_result;
          flags_next = alu_flags;
          skip_next = alu_flags[bos_pkg::FLAG_Z];
        end
        default: skip_next = 1'b0;
      endcase
    end

    // Bit writes to an I/O register touch only the addressed latch
    if (io_wen) begin
      case (OP_ADDR)
        bos_pkg::IO_FLAGS: begin
          if (OP_CODE != bos_pkg::BOS_OP_SWAPC_IO) begin
            flags_next = io_wval[3:0];
          end
        end
        bos_pkg::IO_PORT1_DATA: port_one_data_next = io_wval;
        bos_pkg::IO_PORT1_DIR: port_one_dir_next = io_wval;
        bos_pkg::IO_PORT2_DATA: port_two_data_next = io_wval;
        bos_pkg::IO_PORT2_DIR: port_two_dir_next = io_wval;
        default: io_wval = io_latch;
      endcase
    end

    // Addresses beyond the array write nothing
    if (mem_wen && OP_ADDR < MEM_DEPTH) begin
      mem_next[mem_idx] = mem_wval;
    end
  end

  // Instruction, flag, port and memory state
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      work_register_reg <= bos_pkg::RST_WORK;
      flags_reg <= bos_pkg::RST_FLAGS;
      port_one_data_reg <= bos_pkg::RST_PORT_DATA;
      port_one_dir_reg <= bos_pkg::RST_PORT_DIR;
      port_two_data_reg <= bos_pkg::RST_PORT_DATA;
      port_two_dir_reg <= bos_pkg::RST_PORT_DIR;
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_reg[i] <= bos_pkg::RST_MEM;
      end
      skip_reg <= 1'b0;
      skipped_reg <= 1'b0;
    end else begin
      work_register_reg <= work_register_next;
      flags_reg <= flags_next;
      port_one_data_reg <= port_one_data_next;
      port_one_dir_reg <= port_one_dir_next;
      port_two_data_reg <= port_two_data_next;
      port_two_dir_reg <= port_two_dir_next;
      mem_reg <= mem_next;
      skip_reg <= skip_next;
      skipped_reg <= skipped_next;
    end
  end

  // Read data stands only in the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_next = 8'h00;
    if (BUS_RD) begin
      case (BUS_ADDR)
        bos_pkg::IO_FLAGS: rdata_next = {4'h0, flags_reg};
        bos_pkg::IO_PORT1_DATA: rdata_next = port_one_view;
        bos_pkg::IO_PORT1_DIR: rdata_next = port_one_dir_reg;
        bos_pkg::IO_PORT2_DATA: rdata_next = port_two_view;
        bos_pkg::IO_PORT2_DIR: rdata_next = port_two_dir_reg;
        bos_pkg::REG_WORK: rdata_next = work_register_reg;
        default: begin
          if ((BUS_ADDR & bos_pkg::REG_MEM_MASK) == bos_pkg::REG_MEM_BASE && BUS_ADDR[5:0] < MEM_DEPTH) begin
            rdata_next = mem_reg[BUS_ADDR[MEM_AW-1:0]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign OP_SKIPPED = skipped_reg;
  assign SKIP_PENDING = skip_reg;
  assign WORK_REG = work_register_reg;
  assign FLAGS = flags_reg;
  assign BUS_RDATA = rdata_reg;
  assign PORT1_OUT = port_one_data_reg;
  assign PORT1_OE_N = ~port_one_dir_reg;
  assign PORT2_OUT = port_two_data_reg;
  assign PORT2_OE_N = ~port_two_dir_reg;

endmodule // bos_exec

// >>> src/bos_flag_alu.sv
// Subtract or increment with zero, carry, half-borrow and signed-range flags
`timescale 1ns/1ps
module bos_flag_alu (
  input wire logic [7:0] a, // Work register value
  input wire logic [7:0] b, // Subtrahend
  input wire logic inc, // 1 selects a + 1, 0 selects a - b
  output logic [7:0] result, // Arithmetic result
  output logic [3:0] flags // Flags at package positions
);

  logic [8:0] wide;
  logic half;
  logic ovf;

  always_comb begin
    if (inc) begin
      wide = {1'b0, a} + 9'h001;
      half = (a[3:0] == 4'hF);
      ovf = ~a[7] & wide[7];
    end else begin
      wide = {1'b0, a} - {1'b0, b};
      half = (a[3:0] < b[3:0]);
      ovf = (a[7] ^ b[7]) & (a[7] ^ wide[7]);
    end
    result = wide[7:0];
    flags = 4'h0;
    flags[bos_pkg::FLAG_Z] = (wide[7:0] == 8'h00);
    flags[bos_pkg::FLAG_C] = wide[8];
    flags[bos_pkg::FLAG_AC] = half;
    flags[bos_pkg::FLAG_OV] = ovf;
  end

endmodule // bos_flag_alu

// >>> src/bos_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module bos_pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [WIDTH-1:0] pin_in, // Raw pin levels
  output logic [WIDTH-1:0] level_out // Filtered pin levels
);

  logic [WIDTH-1:0] s1_reg, s1_next;
  logic [WIDTH-1:0] s2_reg, s2_next;
  logic [WIDTH-1:0] s3_reg, s3_next;
  logic [WIDTH-1:0] lvl_reg, lvl_next;

  // A bit only changes once the second and third stages agree
  always_comb begin
    s1_next = pin_in;
    s2_next = s1_reg;
    s3_next = s2_reg;
    lvl_next = lvl_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        lvl_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      lvl_reg <= '0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      lvl_reg <= lvl_next;
    end
  end

  assign level_out = lvl_reg;

endmodule // bos_pin_sync
